//--- core/mafb_pkg.sv
/*
  package of the monitor alarm flag bank: register offsets, bit positions,
  reset values and the carrier structs shared by the design files.
  assumes nothing of its surroundings.
*/
package mafb_pkg;

  // register offsets in module memory
  localparam logic [7:0] CORE_ALARM_OFFSET = 8'h70;
  localparam logic [7:0] AUX_ALARM_OFFSET = 8'h71;
  localparam logic [7:0] FAST_ALARM_OFFSET = 8'h72;

  // reset values
  localparam logic [7:0] CORE_ALARM_RESET = 8'h10;
  localparam logic [7:0] AUX_ALARM_RESET = 8'h00;
  localparam logic [7:0] FAST_ALARM_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // core register bit positions
  localparam int TEMP_HI_BIT = 7;
  localparam int TEMP_LO_BIT = 6;
  localparam int VCC_HI_BIT = 5;
  localparam int VCC_LO_BIT = 4;
  localparam int MONITOR_INPUT_ONE_HI_BIT = 3;
  localparam int MONITOR_INPUT_ONE_LO_BIT = 2;
  localparam int MONITOR_INPUT_TWO_HI_BIT = 1;
  localparam int MONITOR_INPUT_TWO_LO_BIT = 0;
  // aux register bit positions
  localparam int MONITOR_INPUT_THREE_HI_BIT = 7;
  localparam int MONITOR_INPUT_THREE_LO_BIT = 6;
  localparam int MONITOR_INPUT_FOUR_HI_BIT = 5;
  localparam int MONITOR_INPUT_FOUR_LO_BIT = 4;
  localparam int FAULT_SUM_BIT = 0;
  // fast register bit positions
  localparam int HBIAS_BIT = 3;
  localparam int TX_POWER_OVER_FLAG_BIT = 1;
  localparam int TX_POWER_UNDER_FLAG_BIT = 0;

  // measurement channels
  localparam int CHAN_COUNT = 6;
  localparam int CHAN_TEMP = 0;
  localparam int CHAN_VCC = 1;
  localparam int CHAN_MONITOR_INPUT_ONE = 2;
  localparam int CHAN_MONITOR_INPUT_TWO = 3;
  localparam int CHAN_MONITOR_INPUT_THREE = 4;
  localparam int CHAN_MONITOR_INPUT_FOUR = 5;
  localparam int MEAS_WIDTH = 16;
  localparam int WARN_WIDTH = 12;

  // one completed conversion with its thresholds
  typedef struct packed {
    logic done;
    logic isSigned;
    logic [MEAS_WIDTH-1:0] result;
    logic [MEAS_WIDTH-1:0] highLimit;
    logic [MEAS_WIDTH-1:0] lowLimit;
  } mafb_conv_type;

  // fast comparator verdicts
  typedef struct packed {
    logic biasAbove;
    logic biasBelow;
    logic powerAbove;
    logic powerBelow;
  } mafb_fast_type;

  // host read port
  typedef struct packed {
    logic rdStrobe;
    logic wrStrobe;
    logic [7:0] addr;
    logic [7:0] wrData;
  } mafb_host_type;

  // read state machine
  typedef enum logic [1:0] {
    MAFB_IDLE = 2'b00,
    MAFB_LOOKUP = 2'b01,
    MAFB_ANSWER = 2'b11
  } mafb_rdstate_type;

endpackage

//--- core/mafb_threshold_flag.sv
/*
  one high/low alarm pair updated on each completed conversion.
  assumes result and limits are stable while done is high.
*/
`timescale 1ns/10ps
module mafb_threshold_flag
  import mafb_pkg::*;
#(
  parameter logic HIGH_RESET = 1'b0,
  parameter logic LOW_RESET = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire mafb_conv_type conv,
  input wire logic forceLow,
  output logic highFlag,
  output logic lowFlag
);

  typedef struct packed {
    logic high;
    logic low;
  } mafb_pair_type;

  mafb_pair_type state_reg;
  mafb_pair_type state_next;
  logic above;
  logic below;

  // signed for temperature, unsigned for voltages
  always_comb begin
    if (conv.isSigned) begin
      above = $signed(conv.result) > $signed(conv.highLimit);
      below = $signed(conv.result) < $signed(conv.lowLimit);
    end else begin
      above = conv.result > conv.highLimit;
      below = conv.result < conv.lowLimit;
    end
  end

  // refresh both flags per conversion; low held by power-on trip
  always_comb begin
    state_next = state_reg;
    if (conv.done) begin
      state_next.high = above;
      state_next.low = below;
    end
    if (forceLow) begin
      state_next.low = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{high: HIGH_RESET, low: LOW_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign highFlag = state_reg.high;
  assign lowFlag = state_reg.low;

endmodule

//--- core/mafb_fast_flags.sv
/*
  fast-path alarms: high bias, transmit power over and under.
  assumes comparator verdicts are synchronous to clk_sys.
*/
`timescale 1ns/10ps
module mafb_fast_flags
  import mafb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire mafb_fast_type fast,
  input wire logic txDisable,
  output logic high_bias_fast_flag,
  output logic tx_power_over_flag,
  output logic tx_power_under_flag
);

  typedef struct packed {
    logic hbias;
    logic over;
    logic under;
  } mafb_fstate_type;

  mafb_fstate_type state_reg;
  mafb_fstate_type state_next;

  // set/clear per comparison; disable state clears all
  always_comb begin
    state_next = state_reg;
    if (fast.biasAbove) begin
      state_next.hbias = 1'b1;
    end else if (fast.biasBelow) begin
      state_next.hbias = 1'b0;
    end
    if (fast.powerAbove) begin
      state_next.over = 1'b1;
    end else if (fast.powerBelow) begin
      state_next.over = 1'b0;
    end
    if (fast.powerBelow) begin
      state_next.under = 1'b1;
    end else if (fast.powerAbove) begin
      state_next.under = 1'b0;
    end
    if (txDisable) begin
      state_next = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign high_bias_fast_flag = state_reg.hbias;
  assign tx_power_over_flag = state_reg.over;
  assign tx_power_under_flag = state_reg.under;

endmodule

//--- core/mafb_monitor_alarm_flag_bank.sv
/*
  three read-only alarm registers of a transceiver monitor: slow threshold
  flags, fast trip flags and the transmit-fault summary, with a host read
  port into module memory.
  assumes the two-wire bus slave delivers byte reads as one-cycle strobes and
  that conversion done pulses and comparator verdicts are synchronous.
*/
// Summary of operation
// - each temperature conversion sets the high flag above the limit and clears it otherwise.
// - each temperature conversion sets the low flag below the limit and clears it otherwise.
// - each supply conversion sets the supply high flag above the limit and clears it otherwise.
// - supply low flag resets to one, is held while under power-on trip, and clears on a conversion at or above the limit.
// - each first monitor conversion updates its high and low flags.
// - each second monitor conversion updates its high and low flags.
// - third monitor high/low flags follow conversions and ignore transmit disable.
// - fourth monitor high/low flags follow conversions and ignore transmit disable.
// - fault summary is the OR of enabled alarms and warnings plus the unmaskable fast alarms and bias maximum.
// - high-bias flag follows its fast comparison and clears on transmit disable.
// - transmit-power over flag follows its fast comparison and clears on transmit disable.
// - transmit-power under flag follows its fast comparison and clears on transmit disable.
// - transmit disable is the pin ORed with the software disable bit.
`timescale 1ns/10ps
module mafb_monitor_alarm_flag_bank
  import mafb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire mafb_conv_type [CHAN_COUNT-1:0] conv,
  input wire logic power_on_analog_trip,
  input wire mafb_fast_type fast,
  input wire logic bias_max_flag,
  input wire logic txDisablePin,
  input wire logic soft_transmit_disable,
  input wire logic [WARN_WIDTH-1:0] warnFlags,
  input wire logic [WARN_WIDTH-1:0] warnEnable,
  input wire logic [WARN_WIDTH-1:0] alarmEnable,
  input wire mafb_host_type host,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic rdHit,
  output logic transmit_fault_summary,
  output logic txDisableState
);

  typedef struct packed {
    mafb_rdstate_type rdState;
    logic [7:0] addr;
    logic [7:0] data;
    logic hit;
    logic fault;
  } mafb_state_type;

  mafb_state_type state_reg;
  mafb_state_type state_next;
  logic [CHAN_COUNT-1:0] highFlags;
  logic [CHAN_COUNT-1:0] lowFlags;
  logic hbiasFlag;
  logic overFlag;
  logic underFlag;
  logic txDisable;
  logic [WARN_WIDTH-1:0] alarmVector;
  logic [7:0] coreReg;
  logic [7:0] auxReg;
  logic [7:0] fastReg;

  // combined transmit-disable state
  assign txDisable = txDisablePin | soft_transmit_disable;

  // slow-path flag pairs, one per channel
  genvar ch;
  generate
    for (ch = 0; ch < CHAN_COUNT; ch++) begin : gChan
      mafb_threshold_flag #(
        .HIGH_RESET(1'b0),
        .LOW_RESET(ch == CHAN_VCC ? CORE_ALARM_RESET[VCC_LO_BIT] : 1'b0)
      ) uFlag (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .conv(conv[ch]),
        .forceLow(ch == CHAN_VCC ? power_on_analog_trip : 1'b0),
        .highFlag(highFlags[ch]),
        .lowFlag(lowFlags[ch])
      );
    end
  endgenerate

  // fast-path flags
  mafb_fast_flags uFast (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .fast(fast),
    .txDisable(txDisable),
    .high_bias_fast_flag(hbiasFlag),
    .tx_power_over_flag(overFlag),
    .tx_power_under_flag(underFlag)
  );

  // alarm vector in warning order for enable masking
  always_comb begin
    alarmVector = '0;
    for (int i = 0; i < CHAN_COUNT; i++) begin
      alarmVector[WARN_WIDTH-1-2*i] = highFlags[i];
      alarmVector[WARN_WIDTH-2-2*i] = lowFlags[i];
    end
  end

  // register images, reserved bits zero
  always_comb begin
    coreReg = '0;
    coreReg[TEMP_HI_BIT] = highFlags[CHAN_TEMP];
    coreReg[TEMP_LO_BIT] = lowFlags[CHAN_TEMP];
    coreReg[VCC_HI_BIT] = highFlags[CHAN_VCC];
    coreReg[VCC_LO_BIT] = lowFlags[CHAN_VCC];
    coreReg[MONITOR_INPUT_ONE_HI_BIT] = highFlags[CHAN_MONITOR_INPUT_ONE];
    coreReg[MONITOR_INPUT_ONE_LO_BIT] = lowFlags[CHAN_MONITOR_INPUT_ONE];
    coreReg[MONITOR_INPUT_TWO_HI_BIT] = highFlags[CHAN_MONITOR_INPUT_TWO];
    coreReg[MONITOR_INPUT_TWO_LO_BIT] = lowFlags[CHAN_MONITOR_INPUT_TWO];
    auxReg = '0;
    auxReg[MONITOR_INPUT_THREE_HI_BIT] = highFlags[CHAN_MONITOR_INPUT_THREE];
    auxReg[MONITOR_INPUT_THREE_LO_BIT] = lowFlags[CHAN_MONITOR_INPUT_THREE];
    auxReg[MONITOR_INPUT_FOUR_HI_BIT] = highFlags[CHAN_MONITOR_INPUT_FOUR];
    auxReg[MONITOR_INPUT_FOUR_LO_BIT] = lowFlags[CHAN_MONITOR_INPUT_FOUR];
    auxReg[FAULT_SUM_BIT] = state_reg.fault;
    fastReg = '0;
    fastReg[HBIAS_BIT] = hbiasFlag;
    fastReg[TX_POWER_OVER_FLAG_BIT] = overFlag;
    fastReg[TX_POWER_UNDER_FLAG_BIT] = underFlag;
  end

  // read machine and fault summary; writes are ignored
  always_comb begin
    state_next = state_reg;
    state_next.fault = (|(alarmVector & alarmEnable))
                     | (|(warnFlags & warnEnable))
                     | overFlag | underFlag
                     | bias_max_flag | hbiasFlag;
    case (state_reg.rdState)
      MAFB_IDLE: begin
        if (host.rdStrobe) begin
          state_next.addr = host.addr;
          state_next.rdState = MAFB_LOOKUP;
        end
      end
      MAFB_LOOKUP: begin
        state_next.hit = 1'b1;
        case (state_reg.addr)
          CORE_ALARM_OFFSET: state_next.data = coreReg;
          AUX_ALARM_OFFSET: state_next.data = auxReg;
          FAST_ALARM_OFFSET: state_next.data = fastReg;
          default: begin
            state_next.data = READ_IDLE;
            state_next.hit = 1'b0;
          end
        endcase
        state_next.rdState = MAFB_ANSWER;
      end
      MAFB_ANSWER: begin
        state_next.rdState = MAFB_IDLE;
      end
      default: begin
        state_next.rdState = MAFB_IDLE;
      end
    endcase
    // host.wrStrobe deliberately unused: registers are read only
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{rdState: MAFB_IDLE, addr: 8'h00, data: READ_IDLE,
                     hit: 1'b0, fault: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData = state_reg.data;
  assign rdValid = (state_reg.rdState == MAFB_ANSWER);
  assign rdHit = state_reg.hit;
  assign transmit_fault_summary = state_reg.fault;
  assign txDisableState = txDisable;

endmodule

//--- bench/mafb_properties.sv
/*
  port assertions of the alarm flag bank.
  assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/10ps
module mafb_properties
  import mafb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire mafb_fast_type fast,
  input wire logic bias_max_flag,
  input wire logic txDisablePin,
  input wire logic soft_transmit_disable,
  input wire logic [WARN_WIDTH-1:0] warnFlags,
  input wire logic [WARN_WIDTH-1:0] warnEnable,
  input wire logic [WARN_WIDTH-1:0] alarmEnable,
  input wire mafb_host_type host,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic transmit_fault_summary,
  input wire logic txDisableState
);
  logic [1:0] pendReg;
  logic [7:0] addrReg;
  logic quiet;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // disabled with nothing enabled and no bias maximum
  assign quiet = txDisableState && !bias_max_flag && alarmEnable == '0
    && warnEnable == '0;
  // cycles left in the current read and its address
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pendReg <= 2'h0;
      addrReg <= 8'h00;
    end else if (host.rdStrobe && pendReg == 2'h0) begin
      pendReg <= 2'h3; // machine is busy through the answer cycle
      addrReg <= host.addr;
    end else if (pendReg != 2'h0) begin
      pendReg <= pendReg - 2'h1;
    end
  end
  AST_TXDIS_OR:
    assert property (txDisableState == (txDisablePin | soft_transmit_disable))
    else $error("disable state wrong");
  AST_RD_LATENCY:
    assert property (host.rdStrobe && pendReg == 2'h0
      |-> !rdValid ##1 !rdValid ##1 rdValid)
    else $error("read answer late");
  AST_RES_AUX:
    assert property (rdValid && addrReg == AUX_ALARM_OFFSET
      |-> rdData[3:1] == 3'h0)
    else $error("reserved aux bits set");
  AST_RES_FAST:
    assert property (rdValid && addrReg == FAST_ALARM_OFFSET
      |-> rdData[7:4] == 4'h0 && rdData[2] == 1'b0)
    else $error("reserved fast bits set");
  AST_FAST_SUM:
    assert property (fast.powerAbove && !txDisableState
      |-> ##2 transmit_fault_summary)
    else $error("fast alarm not in summary");
  AST_BIAS_SUM:
    assert property (bias_max_flag [*2] |-> transmit_fault_summary)
    else $error("bias maximum not in summary");
  AST_WARN_SUM:
    assert property ((|(warnFlags & warnEnable)) [*2]
      |-> transmit_fault_summary)
    else $error("enabled warning not in summary");
  AST_TXDIS_QUIET:
    assert property (quiet [*3] |-> !transmit_fault_summary)
    else $error("fast alarm survives disable");
  COV_READ: cover property (rdValid);
  COV_SUM: cover property (transmit_fault_summary);
  COV_QUIET: cover property (quiet [*3]);
endmodule

bind mafb_monitor_alarm_flag_bank mafb_properties chk (.clk_sys, .sys_rst,
  .fast, .bias_max_flag, .txDisablePin, .soft_transmit_disable, .warnFlags,
  .warnEnable, .alarmEnable, .host, .rdData, .rdValid,
  .transmit_fault_summary, .txDisableState);

//--- bench/mafb_host_model.sv
/*
  host model: single-byte reads and writes of module memory.
  assumes the read port answers a few cycles after the take edge.
*/
`timescale 1ns/10ps
module mafb_host_model
  import mafb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic rdHit,
  output mafb_host_type host
);
  initial host = '0;
  // strobe one cycle, hold the address until the answer edge
  task automatic readReg(input logic [7:0] a, output logic [7:0] d,
                         output logic h);
    d = 8'hxx;
    h = 1'bx;
    @(posedge clk_sys);
    #1;
    host.rdStrobe = 1'b1;
    host.addr = a;
    @(posedge clk_sys);
    #1;
    host.rdStrobe = 1'b0;
    for (int n = 0; n < 6; n++) begin
      @(posedge clk_sys);
      if (rdValid === 1'b1) begin
        d = rdData;
        h = rdHit;
        break;
      end
    end
    #1;
    host.addr = ~a; // released address stops showing the old value
  endtask
  // one write strobe, expected to be ignored
  task automatic writeReg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    #1;
    host.wrStrobe = 1'b1;
    host.addr = a;
    host.wrData = v;
    @(posedge clk_sys);
    #1;
    host.wrStrobe = 1'b0;
  endtask
endmodule

//--- bench/mafb_monitor_alarm_flag_bank_tb.sv
/*
  testbench of the alarm flag bank: conversions, fast verdicts and
  disables, checked by register reads through the host model.
  assumes package and design compiled first.
*/
`timescale 1ns/10ps
module mafb_monitor_alarm_flag_bank_tb;
  import mafb_pkg::*;
  logic clk_sys, sys_rst, power_on_analog_trip, bias_max_flag;
  logic txDisablePin, soft_transmit_disable, rdValid, rdHit, h;
  logic transmit_fault_summary, txDisableState;
  mafb_conv_type [CHAN_COUNT-1:0] conv;
  mafb_fast_type fast;
  logic [WARN_WIDTH-1:0] warnFlags, warnEnable, alarmEnable;
  mafb_host_type host;
  logic [7:0] rdData, d;
  logic [15:0] expSlow;
  logic [15:0] vals [4] = '{16'h8001, 16'h3fff, 16'h8000, 16'h4000};
  int mismatches, checks;
  mafb_monitor_alarm_flag_bank uut (.clk_sys, .sys_rst, .conv,
    .power_on_analog_trip, .fast, .bias_max_flag, .txDisablePin,
    .soft_transmit_disable, .warnFlags, .warnEnable, .alarmEnable, .host,
    .rdData, .rdValid, .rdHit, .transmit_fault_summary, .txDisableState);
  mafb_host_model hostModel (.clk_sys, .rdData, .rdValid, .rdHit, .host);
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    hostModel.readReg(a, d, h);
    check(d, exp);
  endtask
  task automatic slowChk(input logic sum);
    rdChk(CORE_ALARM_OFFSET, expSlow[15:8]);
    rdChk(AUX_ALARM_OFFSET, {expSlow[7:4], 3'h0, sum});
  endtask
  task automatic sumChk(input logic exp);
    repeat (3) @(posedge clk_sys);
    #1;
    check({7'h0, transmit_fault_summary}, {7'h0, exp});
  endtask
  // one conversion pulse against limits 8000 and 4000
  task automatic doConv(input int ch, input logic [15:0] r, input logic sg);
    logic up, dn;
    up = sg ? $signed(r) > $signed(16'h8000) : r > 16'h8000;
    dn = sg ? $signed(r) < $signed(16'h4000) : r < 16'h4000;
    @(posedge clk_sys);
    #1;
    conv[ch] = '{1'b1, sg, r, 16'h8000, 16'h4000};
    @(posedge clk_sys);
    #1;
    conv[ch].done = 1'b0;
    expSlow[15-2*ch] = up;
    expSlow[14-2*ch] = dn | (power_on_analog_trip && ch == CHAN_VCC);
  endtask
  task automatic fastPulse(input logic [3:0] v);
    @(posedge clk_sys);
    #1;
    fast = v;
    @(posedge clk_sys);
    #1;
    fast = '0;
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {sys_rst, power_on_analog_trip, bias_max_flag} = 3'b100;
    {txDisablePin, soft_transmit_disable} = 2'b00;
    {conv, fast, warnFlags, warnEnable, alarmEnable} = '0;
    expSlow = 16'h1000;
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rdChk(CORE_ALARM_OFFSET, CORE_ALARM_RESET);
    rdChk(AUX_ALARM_OFFSET, AUX_ALARM_RESET);
    rdChk(FAST_ALARM_OFFSET, FAST_ALARM_RESET);
    check({7'h0, h}, 8'h01);
    rdChk(8'h73, READ_IDLE);
    check({7'h0, h}, 8'h00);
    hostModel.writeReg(CORE_ALARM_OFFSET, 8'hef);
    hostModel.writeReg(FAST_ALARM_OFFSET, 8'hff);
    rdChk(CORE_ALARM_OFFSET, CORE_ALARM_RESET);
    rdChk(FAST_ALARM_OFFSET, FAST_ALARM_RESET);
    for (int ch = 0; ch < CHAN_COUNT; ch++) begin
      foreach (vals[i]) begin
        doConv(ch, vals[i], 1'b0);
        slowChk(1'b0);
      end
    end
    doConv(CHAN_TEMP, 16'hfff0, 1'b1);
    slowChk(1'b0);
    for (int t = 1; t >= 0; t--) begin
      power_on_analog_trip = 1'(t);
      doConv(CHAN_VCC, 16'h5000, 1'b0);
      slowChk(1'b0);
    end
    doConv(CHAN_MONITOR_INPUT_THREE, 16'h8001, 1'b0);
    fastPulse(4'b1010);
    rdChk(FAST_ALARM_OFFSET, 8'h0a);
    slowChk(1'b1);
    fastPulse(4'b0101);
    rdChk(FAST_ALARM_OFFSET, 8'h01);
    for (int s = 0; s < 2; s++) begin
      fastPulse(4'b1010);
      rdChk(FAST_ALARM_OFFSET, 8'h0a);
      {soft_transmit_disable, txDisablePin} = 2'(s + 1);
      rdChk(FAST_ALARM_OFFSET, 8'h00);
      slowChk(1'b0);
      check({7'h0, txDisableState}, 8'h01);
      {soft_transmit_disable, txDisablePin} = 2'b00;
    end
    alarmEnable = 12'h008;
    sumChk(1'b1);
    alarmEnable = 12'h004;
    warnFlags = 12'h001;
    sumChk(1'b0);
    warnEnable = 12'h001;
    sumChk(1'b1);
    warnEnable = 12'h000;
    bias_max_flag = 1'b1;
    sumChk(1'b1);
    print_verdict();
  end
endmodule
